//--- hpsr_host_model.sv
/*
  Host-side model of the three shared pins: host drivers, pull-ups and
  the resolved wire level fed back to the pad inputs.
  Assumes the bench sets the host drive enables and levels.
*/
`timescale 1ns/1ps
module hpsr_host_model (
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pin_keep,
  input  wire logic [2:0] host_oe,
  input  wire logic [2:0] host_lvl,
  output logic      [2:0] pin_in
);
  // Pull-ups let a released open-drain request read high, never unknown
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i] || pin_keep[i])
        pin_in[i] = pin_out[i];
      else if (host_oe[i])
        pin_in[i] = host_lvl[i];
      else
        pin_in[i] = 1'b1;
    end
  end
endmodule : hpsr_host_model

//--- hpsr_pin_cell.sv
/*
  One shared pin: two-flop input synchroniser, stop-state input hold and output
  driver with stop-state keeper.
  Assumes pad inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module hpsr_pin_cell (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic pad_in,
  input  wire logic stop_mode,
  input  wire logic want_oe,
  input  wire logic want_out,
  output logic      sync_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      keep_level
);

  logic meta_reg;
  logic sync_reg;
  logic last_out_reg;
  logic last_oe_reg;
  logic held_in_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= pad_in;
      sync_reg <= meta_reg;
    end
  end

  // Direction and level freeze while stopped; the keeper holds an output level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      last_out_reg <= 1'b0;
      last_oe_reg  <= 1'b0;
      held_in_reg  <= 1'b0;
    end else if (!stop_mode) begin
      last_out_reg <= want_out;
      last_oe_reg  <= want_oe;
      held_in_reg  <= sync_reg;
    end
  end

  // Input is ignored in stop: the core sees the last sampled value
  assign sync_in    = stop_mode ? held_in_reg : sync_reg;
  assign pad_out    = last_out_reg;
  assign pad_oe     = last_oe_reg & ~stop_mode;
  // Weak keeper drives the last output level while stopped, for a pin last driven
  assign keep_level = stop_mode & last_oe_reg;

endmodule : hpsr_pin_cell

//--- hpsr_pkg.sv
/*
  Package for the host port strobe/request pin block: configuration carriers,
  register offsets, field positions and reset values.
  Assumes a single core clock domain and a plain strobe register port.
*/
package hpsr_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_POL    = 4'h1;
  localparam logic [3:0] OFS_DDR    = 4'h2;
  localparam logic [3:0] OFS_GPOUT  = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_HOST_EN  = 0;
  localparam int unsigned CTRL_DBL_STRB = 1;
  localparam int unsigned CTRL_DBL_REQ  = 2;
  localparam int unsigned CTRL_OPEN_DR  = 3;
  localparam int unsigned CTRL_REQ_TX   = 4;
  localparam int unsigned CTRL_REQ_RX   = 5;

  // Polarity register fields: 1 means active high
  localparam int unsigned POL_STRB = 0;
  localparam int unsigned POL_REQ  = 1;
  localparam int unsigned POL_ACK  = 2;

  // Reset values: general-purpose, all inputs, all polarities active low
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] POL_RST   = 8'h00;
  localparam logic [2:0] DDR_RST   = 3'h0;
  localparam logic [2:0] GPOUT_RST = 3'h0;

  // Pin indices within the three shared pins
  localparam int unsigned PIN_STRB = 0;
  localparam int unsigned PIN_REQ  = 1;
  localparam int unsigned PIN_ACK  = 2;
  localparam int unsigned NPINS    = 3;

  typedef struct packed {
    logic host_en;
    logic dbl_strb;
    logic dbl_req;
    logic open_drain;
    logic req_tx;
    logic req_rx;
  } hpsr_cfg_t;

  typedef struct packed {
    logic strb_hi;
    logic req_hi;
    logic ack_hi;
  } hpsr_pol_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } hpsr_drive_t;

endpackage : hpsr_pkg

//--- hpsr_top.sv
/*
  Host port strobe, request and acknowledge pin logic: function select,
  polarity, driven/open-drain request outputs, general-purpose fallback.
  Assumes one 25 MHz core clock, active-low async reset and a host on the pins.
*/
// Summary of operation
// - Single-strobe host mode makes pin 0 a strobe input of programmable polarity, low at reset.
// - Double-strobe host mode makes pin 0 the write strobe input, same polarity handling.
// - General-purpose mode makes each pin an input or output by its direction bit.
// - Single-request host mode drives a request output of programmable polarity, low at reset.
// - Every request output may be driven actively or as open drain.
// - Double-request host mode puts the transmit request on the request pin.
// - Single-request host mode takes the host acknowledge input, polarity programmable.
// - Double-request host mode puts the receive request on the acknowledge pin.
// - In stop, a pin last configured as input is ignored.
// - In stop, a pin last configured as output keeps its level through a keeper.
// - Wait state changes no pin function, direction or level.
`timescale 1ns/1ps
module hpsr_top (
  input  wire logic                         core_clk,
  input  wire logic                         nrst,
  input  wire logic [hpsr_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [hpsr_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [hpsr_pkg::DATA_W-1:0]  reg_rdata,
  input  wire logic                         stop_mode,
  input  wire logic                         wait_mode,
  input  wire logic                         host_tx_req,
  input  wire logic                         host_rx_req,
  input  wire logic [hpsr_pkg::NPINS-1:0]   pin_in,
  output logic      [hpsr_pkg::NPINS-1:0]   pin_out,
  output logic      [hpsr_pkg::NPINS-1:0]   pin_oe,
  output logic      [hpsr_pkg::NPINS-1:0]   pin_keep,
  output logic                              host_data_strobe_in,
  output logic                              host_write_strobe_in,
  output logic                              host_acknowledge_in
);

  localparam int unsigned N = hpsr_pkg::NPINS;

  logic [7:0]   ctrl_reg;
  logic [7:0]   pol_reg;
  logic [N-1:0] ddr_reg;
  logic [N-1:0] gpout_reg;
  logic [7:0]   rdata_reg;
  logic         strb_reg;
  logic         wstrb_reg;
  logic         ack_reg;
  logic [N-1:0] out_reg;
  logic [N-1:0] oe_reg;
  logic [N-1:0] keep_reg;

  hpsr_pkg::hpsr_cfg_t   cfg;
  hpsr_pkg::hpsr_pol_t   pol;
  hpsr_pkg::hpsr_drive_t drv;

  logic [N-1:0] sync_in;
  logic [N-1:0] cell_out;
  logic [N-1:0] cell_oe;
  logic [N-1:0] cell_keep;

  assign cfg.host_en    = ctrl_reg[hpsr_pkg::CTRL_HOST_EN];
  assign cfg.dbl_strb   = ctrl_reg[hpsr_pkg::CTRL_DBL_STRB];
  assign cfg.dbl_req    = ctrl_reg[hpsr_pkg::CTRL_DBL_REQ];
  assign cfg.open_drain = ctrl_reg[hpsr_pkg::CTRL_OPEN_DR];
  assign cfg.req_tx     = ctrl_reg[hpsr_pkg::CTRL_REQ_TX];
  assign cfg.req_rx     = ctrl_reg[hpsr_pkg::CTRL_REQ_RX];
  assign pol.strb_hi    = pol_reg[hpsr_pkg::POL_STRB];
  assign pol.req_hi     = pol_reg[hpsr_pkg::POL_REQ];
  assign pol.ack_hi     = pol_reg[hpsr_pkg::POL_ACK];

  // Register decode
  wire wr_ctrl  = reg_wr && (reg_addr == hpsr_pkg::OFS_CTRL);
  wire wr_pol   = reg_wr && (reg_addr == hpsr_pkg::OFS_POL);
  wire wr_ddr   = reg_wr && (reg_addr == hpsr_pkg::OFS_DDR);
  wire wr_gpout = reg_wr && (reg_addr == hpsr_pkg::OFS_GPOUT);

  // Configuration is frozen while stopped so the pins keep their last role
  wire cfg_wr_ok = !stop_mode;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg  <= hpsr_pkg::CTRL_RST;
      pol_reg   <= hpsr_pkg::POL_RST;
      ddr_reg   <= hpsr_pkg::DDR_RST;
      gpout_reg <= hpsr_pkg::GPOUT_RST;
    end else begin
      if (wr_ctrl && cfg_wr_ok)  ctrl_reg  <= reg_wdata;
      if (wr_pol && cfg_wr_ok)   pol_reg   <= reg_wdata;
      if (wr_ddr && cfg_wr_ok)   ddr_reg   <= reg_wdata[N-1:0];
      if (wr_gpout && cfg_wr_ok) gpout_reg <= reg_wdata[N-1:0];
    end
  end

  // Read mux; unmapped offsets read zero
  wire [7:0] status_word = {2'h0, cell_keep, sync_in};
  wire [7:0] rd_mux =
      (reg_addr == hpsr_pkg::OFS_CTRL)   ? ctrl_reg :
      (reg_addr == hpsr_pkg::OFS_POL)    ? pol_reg :
      (reg_addr == hpsr_pkg::OFS_DDR)    ? {5'h00, ddr_reg} :
      (reg_addr == hpsr_pkg::OFS_GPOUT)  ? {5'h00, gpout_reg} :
      (reg_addr == hpsr_pkg::OFS_STATUS) ? status_word : 8'h00;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) rdata_reg <= 8'h00;
    else if (reg_rd) rdata_reg <= rd_mux;
    else rdata_reg <= 8'h00;
  end
  assign reg_rdata = rdata_reg;

  // Request levels, active high internally; polarity applied at the pin
  wire req_single = host_tx_req | host_rx_req | cfg.req_tx | cfg.req_rx;
  wire req_a      = cfg.dbl_req ? (host_tx_req | cfg.req_tx) : req_single;
  wire req_b      = host_rx_req | cfg.req_rx;
  wire lvl_a      = req_a ~^ pol.req_hi;
  wire lvl_b      = req_b ~^ pol.req_hi;

  // Open drain only pulls to the low level and releases otherwise
  wire oe_a = cfg.open_drain ? ~lvl_a : 1'b1;
  wire oe_b = cfg.open_drain ? ~lvl_b : 1'b1;

  // Exactly one function per pin, host role or GP role
  assign drv.oe[hpsr_pkg::PIN_STRB]  = cfg.host_en ? 1'b0 : ddr_reg[hpsr_pkg::PIN_STRB];
  assign drv.out[hpsr_pkg::PIN_STRB] = cfg.host_en ? 1'b0 : gpout_reg[hpsr_pkg::PIN_STRB];
  assign drv.oe[hpsr_pkg::PIN_REQ]   = cfg.host_en ? oe_a : ddr_reg[hpsr_pkg::PIN_REQ];
  assign drv.out[hpsr_pkg::PIN_REQ]  = cfg.host_en ? lvl_a : gpout_reg[hpsr_pkg::PIN_REQ];
  assign drv.oe[hpsr_pkg::PIN_ACK]   = cfg.host_en ? (cfg.dbl_req & oe_b)
                                                   : ddr_reg[hpsr_pkg::PIN_ACK];
  assign drv.out[hpsr_pkg::PIN_ACK]  = cfg.host_en ? (cfg.dbl_req & lvl_b)
                                                   : gpout_reg[hpsr_pkg::PIN_ACK];

  // One cell per pin; wait_mode is deliberately not wired
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_pin
      hpsr_pin_cell u_cell (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .pad_in     (pin_in[gi]),
        .stop_mode  (stop_mode),
        .want_oe    (drv.oe[gi]),
        .want_out   (drv.out[gi]),
        .sync_in    (sync_in[gi]),
        .pad_out    (cell_out[gi]),
        .pad_oe     (cell_oe[gi]),
        .keep_level (cell_keep[gi])
      );
    end
  endgenerate

  // Active strobe and acknowledge decode from synchronised pins, polarity applied
  wire strb_act = sync_in[hpsr_pkg::PIN_STRB] ~^ pol.strb_hi;
  wire ack_act  = sync_in[hpsr_pkg::PIN_ACK] ~^ pol.ack_hi;
  wire hs       = cfg.host_en;
  wire strb_nxt = hs & ~cfg.dbl_strb & strb_act;
  wire wstrb_nxt = hs & cfg.dbl_strb & strb_act;
  wire ack_nxt  = hs & ~cfg.dbl_req & ack_act;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strb_reg  <= 1'b0;
      wstrb_reg <= 1'b0;
      ack_reg   <= 1'b0;
      out_reg   <= '0;
      oe_reg    <= '0;
      keep_reg  <= '0;
    end else begin
      strb_reg  <= strb_nxt;
      wstrb_reg <= wstrb_nxt;
      ack_reg   <= ack_nxt;
      out_reg   <= cell_out;
      oe_reg    <= cell_oe;
      keep_reg  <= cell_keep;
    end
  end

  assign host_data_strobe_in  = strb_reg;
  assign host_write_strobe_in = wstrb_reg;
  assign host_acknowledge_in  = ack_reg;
  assign pin_out  = out_reg;
  assign pin_oe   = oe_reg;
  assign pin_keep = keep_reg;

  // Helper: wait_mode must not perturb pins
  logic wait_d_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) wait_d_reg <= 1'b0;
    else wait_d_reg <= wait_mode;
  end

  property p_strobe_single;
    @(posedge core_clk) disable iff (!nrst)
      (hs && !cfg.dbl_strb && strb_act && !stop_mode) |=> host_data_strobe_in;
  endproperty
  a_strobe_single: assert property (p_strobe_single)
    else $error("data strobe not seen");

  property p_strobe_double;
    @(posedge core_clk) disable iff (!nrst)
      (hs && cfg.dbl_strb) |=> !host_data_strobe_in || $past(!hs || !cfg.dbl_strb, 1);
  endproperty
  a_strobe_double: assert property (p_strobe_double)
    else $error("single strobe active in double mode");

  property p_gp_dir;
    @(posedge core_clk) disable iff (!nrst)
      (!hs && !stop_mode) ##1 !stop_mode |-> ##1 (pin_oe == $past(ddr_reg, 2));
  endproperty
  a_gp_dir: assert property (p_gp_dir)
    else $error("gp direction mismatch");

  property p_req_drive;
    @(posedge core_clk) disable iff (!nrst)
      (hs && !cfg.open_drain && !stop_mode) |=> ##1 pin_oe[hpsr_pkg::PIN_REQ] || stop_mode
        || $past(stop_mode);
  endproperty
  a_req_drive: assert property (p_req_drive)
    else $error("request not driven");

  property p_open_drain;
    @(posedge core_clk) disable iff (!nrst)
      (pin_oe[hpsr_pkg::PIN_REQ] && $past(hs, 2) && $past(cfg.open_drain, 2)
        && $past(hs, 1) && $past(cfg.open_drain, 1)) |-> !pin_out[hpsr_pkg::PIN_REQ];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove high");

  property p_ack_double;
    @(posedge core_clk) disable iff (!nrst)
      (hs && cfg.dbl_req) |=> !host_acknowledge_in;
  endproperty
  a_ack_double: assert property (p_ack_double)
    else $error("ack seen in double request mode");

  property p_stop_keep;
    @(posedge core_clk) disable iff (!nrst)
      (stop_mode && $past(stop_mode)) |=> $stable(pin_out) && (pin_oe == '0);
  endproperty
  a_stop_keep: assert property (p_stop_keep)
    else $error("stop level not held");

  property p_wait_neutral;
    @(posedge core_clk) disable iff (!nrst)
      (wait_mode != wait_d_reg) && $stable(ctrl_reg) && $stable(ddr_reg)
        && $stable(sync_in) && !stop_mode |=> $stable(host_acknowledge_in);
  endproperty
  a_wait_neutral: assert property (p_wait_neutral)
    else $error("wait changed pin state");

  property p_tx_req_pin;
    @(posedge core_clk) disable iff (!nrst)
      (hs && cfg.dbl_req && !stop_mode) |-> ##2
        (pin_out[hpsr_pkg::PIN_REQ] == $past((host_tx_req | cfg.req_tx) ~^ pol.req_hi, 2));
  endproperty
  a_tx_req_pin: assert property (p_tx_req_pin)
    else $error("transmit request level wrong");

  property p_ack_single;
    @(posedge core_clk) disable iff (!nrst)
      (hs && !cfg.dbl_req && (sync_in[hpsr_pkg::PIN_ACK] ~^ pol.ack_hi)) |=> host_acknowledge_in;
  endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("acknowledge not seen");

  property p_stop_ignore;
    @(posedge core_clk) disable iff (!nrst)
      (stop_mode && $past(stop_mode)) |-> $stable(sync_in);
  endproperty
  a_stop_ignore: assert property (p_stop_ignore)
    else $error("input followed pin in stop");

  property p_one_role;
    @(posedge core_clk) disable iff (!nrst)
      (hs && !stop_mode) |-> ##2 !pin_oe[hpsr_pkg::PIN_STRB]
        && ($past(cfg.dbl_req, 2) || !pin_oe[hpsr_pkg::PIN_ACK]);
  endproperty
  a_one_role: assert property (p_one_role)
    else $error("host input pin driven");

endmodule : hpsr_top

//--- test_hpsr_top.sv
/*
  Self-checking bench for the shared strobe/request/acknowledge pins.
  Assumes the host model resolves the pad wires and a 25 MHz core clock.
*/
`timescale 1ns/1ps
module test_hpsr_top;
  logic       core_clk, nrst, reg_wr, reg_rd, stop_mode, wait_mode;
  logic       host_tx_req, host_rx_req, data_strb, write_strb, ack_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [2:0] pin_in, pin_out, pin_oe, pin_keep, host_oe, host_lvl;
  int         n_mismatch, check_count, cycles;

  hpsr_top i_hpsr_top (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .host_tx_req(host_tx_req),
    .host_rx_req(host_rx_req), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_keep(pin_keep), .host_data_strobe_in(data_strb), .host_write_strobe_in(write_strb),
    .host_acknowledge_in(ack_seen));
  hpsr_host_model i_hpsr_host_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_keep(pin_keep), .host_oe(host_oe), .host_lvl(host_lvl), .pin_in(pin_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // A hang costs one mismatch; the whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk_pin

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    rv = reg_rdata;
  endtask : rd

  // Covers the 3-edge input path and the 2-edge drive path with margin
  task automatic settle;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic t_reset;
    chk_pin(3'h0, pin_oe);
    rd(hpsr_pkg::OFS_CTRL);
    chk_reg(hpsr_pkg::CTRL_RST, rv);
    rd(hpsr_pkg::OFS_POL);
    chk_reg(hpsr_pkg::POL_RST, rv);
    rd(hpsr_pkg::OFS_DDR);
    chk_reg({5'h00, hpsr_pkg::DDR_RST}, rv);
    rd(4'hf);
    chk_reg(8'h00, rv);
  endtask : t_reset

  task automatic t_strobe;
    host_oe  <= 3'h5;
    host_lvl <= 3'h6;
    wr(hpsr_pkg::OFS_CTRL, 8'h01);
    settle();
    chk_pin(3'h4, {data_strb, write_strb, ack_seen});
    wr(hpsr_pkg::OFS_POL, 8'h01);
    settle();
    chk_pin(3'h0, {data_strb, write_strb, ack_seen});
    host_lvl <= 3'h7;
    wr(hpsr_pkg::OFS_CTRL, 8'h03);
    settle();
    chk_pin(3'h2, {data_strb, write_strb, ack_seen});
    wr(hpsr_pkg::OFS_POL, 8'h00);
  endtask : t_strobe

  task automatic t_request;
    wr(hpsr_pkg::OFS_CTRL, 8'h01);
    host_tx_req <= 1'b1;
    settle();
    chk_pin(3'h2, pin_oe);
    chk_pin(3'h0, pin_out & 3'h2);
    @(posedge core_clk);
    host_tx_req <= 1'b0;
    host_lvl    <= 3'h3;
    settle();
    chk_pin(3'h2, pin_out & 3'h2);
    chk_pin(3'h1, {2'h0, ack_seen});
    @(posedge core_clk);
    host_lvl    <= 3'h7;
    host_rx_req <= 1'b1;
    wr(hpsr_pkg::OFS_POL, 8'h02);
    settle();
    chk_pin(3'h2, pin_out & 3'h2);
    // Acknowledge turned active high while the host holds the pin high
    wr(hpsr_pkg::OFS_POL, 8'h06);
    settle();
    chk_pin(3'h1, {2'h0, ack_seen});
    wr(hpsr_pkg::OFS_POL, 8'h00);
    wr(hpsr_pkg::OFS_CTRL, 8'h09);
    settle();
    chk_pin(3'h2, pin_oe);
    @(posedge core_clk);
    host_rx_req <= 1'b0;
    settle();
    chk_pin(3'h0, pin_oe);
    // Software request bits alone must raise the request
    wr(hpsr_pkg::OFS_CTRL, 8'h39);
    settle();
    chk_pin(3'h2, pin_oe);
    chk_pin(3'h0, pin_out & 3'h2);
    @(posedge core_clk);
    host_oe     <= 3'h1;
    host_tx_req <= 1'b1;
    wr(hpsr_pkg::OFS_CTRL, 8'h05);
    settle();
    chk_pin(3'h6, pin_oe);
    chk_pin(3'h4, pin_out & 3'h6);
    @(posedge core_clk);
    host_tx_req <= 1'b0;
    host_rx_req <= 1'b1;
    wr(hpsr_pkg::OFS_CTRL, 8'h0d);
    settle();
    chk_pin(3'h4, pin_oe);
    chk_pin(3'h0, pin_out & 3'h4);
    @(posedge core_clk);
    host_rx_req <= 1'b0;
  endtask : t_request

  task automatic t_gpio_stop;
    host_oe  <= 3'h2;
    host_lvl <= 3'h2;
    wr(hpsr_pkg::OFS_CTRL, 8'h00);
    wr(hpsr_pkg::OFS_DDR, 8'h05);
    wr(hpsr_pkg::OFS_GPOUT, 8'h01);
    settle();
    chk_pin(3'h5, pin_oe);
    chk_pin(3'h1, pin_out & 3'h5);
    rd(hpsr_pkg::OFS_STATUS);
    chk_reg(8'h03, rv);
    @(posedge core_clk);
    wait_mode <= 1'b1;
    settle();
    chk_pin(3'h5, pin_oe);
    rd(hpsr_pkg::OFS_STATUS);
    chk_reg(8'h03, rv);
    @(posedge core_clk);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    settle();
    chk_pin(3'h5, pin_keep);
    chk_pin(3'h1, pin_out & 3'h5);
    host_lvl <= 3'h0;
    wr(hpsr_pkg::OFS_DDR, 8'h00);
    settle();
    rd(hpsr_pkg::OFS_STATUS);
    chk_reg(8'h2b, rv);
    @(posedge core_clk);
    stop_mode <= 1'b0;
    settle();
    chk_pin(3'h0, pin_keep);
    rd(hpsr_pkg::OFS_DDR);
    chk_reg(8'h05, rv);
  endtask : t_gpio_stop

  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, stop_mode, wait_mode, host_tx_req, host_rx_req} = 6'h00;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    host_oe   = 3'h0;
    host_lvl  = 3'h7;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    t_reset();
    t_strobe();
    t_request();
    t_gpio_stop();
    give_verdict();
  end
endmodule : test_hpsr_top
